// File: include/switch_table_defines.svh
// constants for the switch address table engine and its host controller
`ifndef SWITCH_TABLE_DEFINES_SVH
`define SWITCH_TABLE_DEFINES_SVH

`define TABLE_ENTRIES      512
`define NUM_PORTS          3
`define CLK_PERIOD_NS      20
`define MS_TIME_NS         1000000
`define MS_CYCLES          (`MS_TIME_NS / `CLK_PERIOD_NS)
`define MS_PER_SECOND      10'h3E8
`define AGE_FULL           2'h3
`define LAST_INDEX         9'h1FF

// host register offsets (byte addresses)
`define REG_COMMAND        12'h000
`define REG_STATUS         12'h004
`define REG_WRITE_LOW      12'h008
`define REG_WRITE_HIGH     12'h00C
`define REG_READ_LOW       12'h010
`define REG_READ_HIGH      12'h014

// command register bits
`define CMD_MAKE_BIT       0
`define CMD_FIRST_BIT      1
`define CMD_NEXT_BIT       2
// status register bits
`define STS_PENDING_BIT    0
// high data word field positions
`define HI_PORTS_LSB       16
`define HI_VALID_BIT       19
`define HI_STATIC_BIT      20
`define HI_AGE_LSB         21
`define HI_FILTER_BIT      23
`define HI_PRIO_EN_BIT     24
`define HI_PRIO_LSB        25
`define HI_END_BIT         31

`endif

// File: include/switch_table_pkg.sv
// types shared by both ends of the table link
package switch_table_pkg;

    typedef struct packed {
        logic [47:0] mac;
        logic [2:0]  ports;
        logic        valid;
        logic        isStatic;
        logic [1:0]  age;
        logic        filter;
        logic        prioEn;
        logic [2:0]  prio;
    } entry_t;

    typedef enum logic [1:0] {CMD_MAKE, CMD_FIRST, CMD_NEXT} table_cmd_t;

    typedef enum logic [1:0] {PS_DISABLED, PS_BLOCKING, PS_LEARNING, PS_FORWARDING} tree_state_t;

    typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_WALK} engine_state_t;

    typedef struct packed {
        engine_state_t st;
        entry_t [511:0] tbl;
        logic [8:0]  scanIdx;
        logic [8:0]  walkPos;
        logic        scanDue;
        logic        cmdReq;
        table_cmd_t  cmd;
        entry_t      wr;
        logic        pending;
        entry_t      rd;
        logic        rdEnd;
        logic [15:0] msCnt;
        logic [9:0]  unitCnt;
        logic [19:0] periodCnt;
        logic        ready;
        logic        resValid;
        logic [2:0]  resDest;
        logic        resFilter;
        logic        resPrioValid;
        logic [2:0]  resPrio;
        logic        resTreeOvr;
    } engine_regs_t;

    typedef struct packed {
        logic        cmdValid;
        table_cmd_t  cmdCode;
        logic [31:0] wrLow;
        logic [31:0] wrHigh;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ctrl_regs_t;

endpackage

// File: include/table_link_if.sv
// link between the table engine and its host controller
`timescale 1ns/100ps
interface table_link_if;
    import switch_table_pkg::*;
    logic       cmdValid;
    table_cmd_t cmdCode;
    entry_t     wrEntry;
    logic       pending;
    entry_t     rdEntry;
    logic       rdEnd;

    modport engine (input cmdValid, input cmdCode, input wrEntry,
                    output pending, output rdEntry, output rdEnd);
    modport host   (output cmdValid, output cmdCode, output wrEntry,
                    input pending, input rdEntry, input rdEnd);
endinterface

// File: logic/address_resolver.sv
// address table engine: lookup, learning, aging, host commands
// How it works
// - 512 entries; hit gives ports, filter, priority, override
// - learn unknown source into an empty slot, refresh known, migrate port
// - no learning where port learning disabled
// - scans decrement age, remove learned at zero
// - unrefreshed entry removed after four scans
// - aging period counted in one-second steps
// - age test switches unit to milliseconds
// - aging disabled means no scans at all
// - static entries never aged nor learned over
// - destination may be any port combination
// - filter bit on hit drops packet
// - software installs reserved bridge addresses itself
// - static plus override bypasses tree state except disabled
// - entry priority used when both enables set
// - per-port override replaces destination, keeps rest
// - software loads data, valid zero deletes, make
// - pending held until command completes
// - walk via first/next, valid and end flags
// - walk order is slot order, not insertion
// - single destination equal to source is filtered
// - disabled source port filters everything
// - learning or blocking source filters unless override
// - three ports, any frame tagging and encapsulation
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "switch_table_defines.svh"
module address_resolver #(
    parameter logic [15:0] MS_CYCLES = 16'(`MS_CYCLES)
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // host table link
    table_link_if.engine     link,
    // lookup request from port macs
    input  wire logic        lkValid,
    output      logic        lkReady,
    input  wire logic [1:0]  lkSrcPort,
    input  wire logic [47:0] lkSrcMac,
    input  wire logic [47:0] lkDstMac,
    // lookup result to buffer manager
    output      logic        resValid,
    output      logic [2:0]  resDest,
    output      logic        resFilter,
    output      logic        resPrioValid,
    output      logic [2:0]  resPrio,
    output      logic        resTreeOvr,
    // configuration
    input  wire logic [2:0]  learnEnable,
    input  wire logic [19:0] ageTime,
    input  wire logic        ageTest,
    input  wire logic        ageEnable,
    input  wire logic        daPrioEnable,
    input  wire logic [2:0]  overrideEnable,
    input  wire logic [8:0]  overrideDest,
    input  wire switch_table_pkg::tree_state_t [2:0] portState
);
    import switch_table_pkg::*;

    engine_regs_t r_reg;
    engine_regs_t r_next;

    // direct mapped: slot in one cycle, no chaining
    function automatic logic [8:0] slotOf(input logic [47:0] m);
        slotOf = m[8:0] ^ m[17:9] ^ m[26:18] ^ m[35:27] ^ m[44:36] ^ {6'h00, m[47:45]};
    endfunction

    // flood to forwarding ports but the source
    logic [2:0] floodMask;
    genvar gp;
    generate
        for (gp = 0; gp < `NUM_PORTS; gp++)
        begin : g_flood
            assign floodMask[gp] = (portState[gp] == PS_FORWARDING) && (lkSrcPort != 2'(gp));
        end
    endgenerate

    always_comb
    begin
        logic [8:0]  dSlot;
        logic [8:0]  sSlot;
        logic [8:0]  mSlot;
        logic        hit;
        logic        known;
        logic        treeOvr;
        logic [2:0]  srcBit;
        logic [19:0] period;
        logic [9:0]  unitLen;
        logic        tick;
        entry_t      dEnt;
        entry_t      sEnt;
        entry_t      aEnt;
        dSlot   = slotOf(lkDstMac);
        sSlot   = slotOf(lkSrcMac);
        mSlot   = slotOf(r_reg.wr.mac);
        dEnt    = r_reg.tbl[dSlot];
        sEnt    = r_reg.tbl[sSlot];
        aEnt    = r_reg.tbl[r_reg.scanIdx];
        hit     = dEnt.valid && (dEnt.mac == lkDstMac);
        known   = sEnt.valid && (sEnt.mac == lkSrcMac);
        treeOvr = hit && dEnt.isStatic && dEnt.age[1];
        srcBit  = 3'h1 << lkSrcPort;
        period  = (ageTime == 20'h0_0000) ? 20'h0_0001 : ageTime;
        unitLen = ageTest ? 10'h001 : `MS_PER_SECOND;
        tick    = 1'b0;
        r_next  = r_reg;
        r_next.resValid = 1'b0;

        // time base: cycles, ms, unit, period
        if (!ageEnable)
        begin
            r_next.msCnt     = 16'h0000;
            r_next.unitCnt   = 10'h000;
            r_next.periodCnt = 20'h0_0000;
        end
        else if (r_reg.msCnt == MS_CYCLES - 16'h0001)
        begin
            r_next.msCnt = 16'h0000;
            if (r_reg.unitCnt >= unitLen - 10'h001)
            begin
                r_next.unitCnt = 10'h000;
                if (r_reg.periodCnt >= period - 20'h0_0001)
                begin
                    r_next.periodCnt = 20'h0_0000;
                    tick = 1'b1;
                end
                else
                begin
                    r_next.periodCnt = r_reg.periodCnt + 20'h0_0001;
                end
            end
            else
            begin
                r_next.unitCnt = r_reg.unitCnt + 10'h001;
            end
        end
        else
        begin
            r_next.msCnt = r_reg.msCnt + 16'h0001;
        end
        if (tick)
        begin
            r_next.scanDue = 1'b1;
        end

        // latch host command; pending rises at once
        if (link.cmdValid)
        begin
            r_next.cmdReq  = 1'b1;
            r_next.cmd     = link.cmdCode;
            r_next.wr      = link.wrEntry;
            r_next.pending = 1'b1;
        end

        // one table access per cycle keeps entries whole
        case (r_reg.st)
            ST_IDLE:
            begin
                if (lkValid && r_reg.ready)
                begin
                    r_next.resValid  = 1'b1;
                    r_next.resTreeOvr = treeOvr;
                    r_next.resDest   = overrideEnable[lkSrcPort] ? overrideDest[lkSrcPort*3 +: 3]
                                     : hit ? dEnt.ports : floodMask;
                    r_next.resPrioValid = daPrioEnable && hit && dEnt.prioEn;
                    r_next.resPrio   = dEnt.prio;
                    r_next.resFilter = (portState[lkSrcPort] == PS_DISABLED)
                        || ((portState[lkSrcPort] != PS_FORWARDING) && !treeOvr)
                        || (hit && dEnt.filter)
                        || (hit && !overrideEnable[lkSrcPort] && dEnt.ports == srcBit);
                    if (learnEnable[lkSrcPort])
                    begin
                        if (known && !sEnt.isStatic)
                        begin
                            r_next.tbl[sSlot].ports = srcBit;
                            r_next.tbl[sSlot].age   = `AGE_FULL;
                        end
                        else if (!sEnt.valid)
                        begin
                            r_next.tbl[sSlot] = '{mac: lkSrcMac, ports: srcBit, valid: 1'b1,
                                                  age: `AGE_FULL, default: '0};
                        end
                    end
                end
                else if (r_reg.cmdReq)
                begin
                    r_next.cmdReq = link.cmdValid;
                    case (r_reg.cmd)
                        CMD_MAKE:
                        begin
                            // host entry overwrites a colliding slot
                            if (r_reg.wr.valid)
                            begin
                                r_next.tbl[mSlot] = r_reg.wr;
                            end
                            else if (r_reg.tbl[mSlot].mac == r_reg.wr.mac)
                            begin
                                r_next.tbl[mSlot] = '0;
                            end
                            r_next.pending = link.cmdValid;
                        end
                        CMD_FIRST:
                        begin
                            r_next.walkPos = 9'h000;
                            r_next.st      = ST_WALK;
                        end
                        default:
                        begin
                            if (r_reg.rdEnd)
                            begin
                                r_next.pending = link.cmdValid;
                            end
                            else
                            begin
                                r_next.st = ST_WALK;
                            end
                        end
                    endcase
                end
                else if (r_reg.scanDue)
                begin
                    r_next.scanDue = tick;
                    r_next.scanIdx = 9'h000;
                    r_next.st      = ST_SCAN;
                end
            end
            ST_SCAN:
            begin
                // lookups stall while scanning: entries stay atomic
                if (aEnt.valid && !aEnt.isStatic)
                begin
                    if (aEnt.age == 2'h0)
                    begin
                        r_next.tbl[r_reg.scanIdx] = '0;
                    end
                    else
                    begin
                        r_next.tbl[r_reg.scanIdx].age = aEnt.age - 2'h1;
                    end
                end
                r_next.scanIdx = r_reg.scanIdx + 9'h001;
                if (r_reg.scanIdx == `LAST_INDEX)
                begin
                    r_next.st = ST_IDLE;
                end
            end
            ST_WALK:
            begin
                // slot order
                r_next.walkPos = r_reg.walkPos + 9'h001;
                if (r_reg.tbl[r_reg.walkPos].valid || r_reg.walkPos == `LAST_INDEX)
                begin
                    r_next.rd      = r_reg.tbl[r_reg.walkPos];
                    r_next.rdEnd   = (r_reg.walkPos == `LAST_INDEX);
                    r_next.pending = link.cmdValid;
                    r_next.st      = ST_IDLE;
                end
            end
            default:
            begin
                r_next.st = ST_IDLE;
            end
        endcase

        r_next.ready = (r_next.st == ST_IDLE) && !r_next.cmdReq && !r_next.scanDue;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign lkReady      = r_reg.ready;
    assign resValid     = r_reg.resValid;
    assign resDest      = r_reg.resDest;
    assign resFilter    = r_reg.resFilter;
    assign resPrioValid = r_reg.resPrioValid;
    assign resPrio      = r_reg.resPrio;
    assign resTreeOvr   = r_reg.resTreeOvr;
    assign link.pending = r_reg.pending;
    assign link.rdEntry = r_reg.rd;
    assign link.rdEnd   = r_reg.rdEnd;

endmodule // address_resolver

// File: logic/table_controller.sv
// host controller: apb registers issuing table commands
`timescale 1ns/100ps
`include "switch_table_defines.svh"
module table_controller (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    // table link
    table_link_if.host       link
);
    import switch_table_pkg::*;

    ctrl_regs_t r_reg;
    ctrl_regs_t r_next;

    always_comb
    begin
        logic       mapped;
        logic       take;
        logic [31:0] rdHigh;
        mapped = (paddr == `REG_COMMAND) || (paddr == `REG_STATUS)
              || (paddr == `REG_WRITE_LOW) || (paddr == `REG_WRITE_HIGH)
              || (paddr == `REG_READ_LOW) || (paddr == `REG_READ_HIGH);
        take   = psel && penable && r_reg.pready;
        rdHigh = {link.rdEnd, 3'h0, link.rdEntry.prio, link.rdEntry.prioEn,
                  link.rdEntry.filter, link.rdEntry.age, link.rdEntry.isStatic,
                  link.rdEntry.valid, link.rdEntry.ports, link.rdEntry.mac[47:32]};
        r_next = r_reg;
        r_next.cmdValid = 1'b0;
        // zero wait: data latched in setup
        r_next.pready  = psel && !penable;
        r_next.pslverr = psel && !penable && !mapped;
        if (psel && !penable)
        begin
            case (paddr)
                // own pulse counts so a quick poll sees it
                `REG_STATUS:     r_next.prdata = {31'h0, link.pending | r_reg.cmdValid};
                `REG_WRITE_LOW:  r_next.prdata = r_reg.wrLow;
                `REG_WRITE_HIGH: r_next.prdata = r_reg.wrHigh;
                `REG_READ_LOW:   r_next.prdata = link.rdEntry.mac[31:0];
                `REG_READ_HIGH:  r_next.prdata = rdHigh;
                default:         r_next.prdata = 32'h0000_0000;
            endcase
        end
        if (take && pwrite)
        begin
            case (paddr)
                `REG_WRITE_LOW:  r_next.wrLow  = pwdata;
                `REG_WRITE_HIGH: r_next.wrHigh = pwdata;
                `REG_COMMAND:
                begin
                    // one command per write; make wins over walk bits
                    if (pwdata[`CMD_MAKE_BIT])
                    begin
                        r_next.cmdValid = 1'b1;
                        r_next.cmdCode  = CMD_MAKE;
                    end
                    else if (pwdata[`CMD_FIRST_BIT])
                    begin
                        r_next.cmdValid = 1'b1;
                        r_next.cmdCode  = CMD_FIRST;
                    end
                    else if (pwdata[`CMD_NEXT_BIT])
                    begin
                        r_next.cmdValid = 1'b1;
                        r_next.cmdCode  = CMD_NEXT;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign prdata        = r_reg.prdata;
    assign pready        = r_reg.pready;
    assign pslverr       = r_reg.pslverr;
    assign link.cmdValid = r_reg.cmdValid;
    assign link.cmdCode  = r_reg.cmdCode;
    assign link.wrEntry  = '{mac: {r_reg.wrHigh[15:0], r_reg.wrLow},
                             ports: r_reg.wrHigh[`HI_PORTS_LSB +: 3],
                             valid: r_reg.wrHigh[`HI_VALID_BIT],
                             isStatic: r_reg.wrHigh[`HI_STATIC_BIT],
                             age: r_reg.wrHigh[`HI_AGE_LSB +: 2],
                             filter: r_reg.wrHigh[`HI_FILTER_BIT],
                             prioEn: r_reg.wrHigh[`HI_PRIO_EN_BIT],
                             prio: r_reg.wrHigh[`HI_PRIO_LSB +: 3]};

endmodule // table_controller

// File: bench/switch_table_chk.sv
// checker on the table link
`timescale 1ns/100ps
module switch_table_chk (
    // clock and reset
    input wire logic                         ref_clk,
    input wire logic                         rst,
    // table link
    input wire logic                         cmdValid,
    input wire switch_table_pkg::table_cmd_t cmdCode,
    input wire switch_table_pkg::entry_t     wrEntry,
    input wire logic                         pending,
    input wire switch_table_pkg::entry_t     rdEntry,
    input wire logic                         rdEnd
);
    import switch_table_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_pend_set; cmdValid |=> pending; endproperty
    property p_pend_cause; $rose(pending) |-> $past(cmdValid); endproperty
    // a running scan may delay a make 512 cycles
    property p_make_done; cmdValid && cmdCode == CMD_MAKE |-> ##[2:600] !pending; endproperty
    property p_cmd_pulse; cmdValid |=> !cmdValid; endproperty
    property p_no_cmd_busy; pending |-> !cmdValid; endproperty
    property p_rd_hold; !$fell(pending) |-> $stable(rdEntry); endproperty
    property p_end_hold; !$fell(pending) |-> $stable(rdEnd); endproperty
    property p_wr_hold; pending |-> $stable(wrEntry); endproperty
    a_pend_set: assert property (p_pend_set) else $error("pending not set");
    a_pend_cause: assert property (p_pend_cause) else $error("pending without command");
    a_make_done: assert property (p_make_done) else $error("make never completed");
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command longer than one cycle");
    a_no_cmd_busy: assert property (p_no_cmd_busy) else $error("command while pending");
    a_rd_hold: assert property (p_rd_hold) else $error("read entry moved early");
    a_end_hold: assert property (p_end_hold) else $error("end flag moved early");
    a_wr_hold: assert property (p_wr_hold) else $error("write entry moved while busy");
    c_make: cover property (cmdValid && cmdCode == CMD_MAKE);
    c_next: cover property (cmdValid && cmdCode == CMD_NEXT);
    c_walk_end: cover property ($fell(pending) && rdEnd);
endmodule // switch_table_chk

// File: bench/tb_switch_address_table_engine.sv
// self-checking bench for the table controller and engine
`timescale 1ns/100ps
`include "switch_table_defines.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t got %h expected %h", $time, a, e); end end
module tb_switch_address_table_engine;
    import switch_table_pkg::*;
    typedef struct packed {
        logic [1:0]  src;
        logic [47:0] sa;
        logic [47:0] da;
        logic [2:0]  dest;
        logic        filt;
    } row_t;
    localparam logic [47:0] MA = 48'h0200_0000_0001, MB = 48'h0200_0000_0002;
    localparam logic [47:0] MC = 48'h0200_0000_0003, MD = 48'h0200_0000_0004;
    localparam logic [47:0] ME = 48'h0200_0000_0005, MU = 48'h0200_0000_0009;
    localparam logic [47:0] MM = 48'h0100_5E00_0010, MF = 48'h0180_C200_0001;
    localparam logic [47:0] MS = 48'h0180_C200_0000;
    logic              ref_clk, rst, lkValid, lkReady, ageTest, ageEnable, daPrioEnable;
    logic              resValid, resFilter, resPrioValid, resTreeOvr, psel, penable, pwrite;
    logic              pready, pslverr, rerr;
    logic [1:0]        lkSrcPort;
    logic [2:0]        resDest, resPrio, learnEnable, overrideEnable;
    logic [4:0]        gExt;
    logic [8:0]        overrideDest;
    logic [11:0]       paddr;
    logic [19:0]       ageTime;
    logic [31:0]       pwdata, prdata, rdat, st0;
    logic [47:0]       lkSrcMac, lkDstMac;
    tree_state_t [2:0] portState;
    row_t              rows [7];
    int                error_cnt, n_checks, k, n;

    table_link_if table_link_if_i ();
    address_resolver #(.MS_CYCLES(16'h03E8)) address_resolver_i (
        .ref_clk(ref_clk), .rst(rst), .link(table_link_if_i), .lkValid(lkValid),
        .lkReady(lkReady), .lkSrcPort(lkSrcPort), .lkSrcMac(lkSrcMac), .lkDstMac(lkDstMac),
        .resValid(resValid), .resDest(resDest), .resFilter(resFilter),
        .resPrioValid(resPrioValid), .resPrio(resPrio), .resTreeOvr(resTreeOvr),
        .learnEnable(learnEnable), .ageTime(ageTime), .ageTest(ageTest), .ageEnable(ageEnable),
        .daPrioEnable(daPrioEnable), .overrideEnable(overrideEnable),
        .overrideDest(overrideDest), .portState(portState));
    table_controller table_controller_i (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link(table_link_if_i));
    switch_table_chk switch_table_chk_i (
        .ref_clk(ref_clk), .rst(rst), .cmdValid(table_link_if_i.cmdValid),
        .cmdCode(table_link_if_i.cmdCode), .wrEntry(table_link_if_i.wrEntry),
        .pending(table_link_if_i.pending), .rdEntry(table_link_if_i.rdEntry),
        .rdEnd(table_link_if_i.rdEnd));

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic bound(input logic bad);
        `CHK(bad, 1'b0)
        if (bad)
            give_verdict();
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (k = 0; k < 50 && pready !== 1'b1; k++)
            @(posedge ref_clk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        bound(k >= 50);
    endtask

    // poll until pending drops
    task automatic cmd(input logic [31:0] c);
        apb(1'b1, `REG_COMMAND, c);
        apb(1'b0, `REG_STATUS, 32'h0000_0000);
        st0 = rdat;
        for (int i = 0; i < 3000 && rdat[`STS_PENDING_BIT] !== 1'b0; i++)
            apb(1'b0, `REG_STATUS, 32'h0000_0000);
        bound(rdat[`STS_PENDING_BIT] !== 1'b0);
    endtask

    task automatic make(input logic [47:0] m, input logic [11:0] f);
        apb(1'b1, `REG_WRITE_LOW, m[31:0]);
        apb(1'b1, `REG_WRITE_HIGH, {4'h0, f, m[47:32]});
        cmd(32'h0000_0001);
    endtask

    // dest means nothing on a dropped packet
    task automatic look(input logic [1:0] s, input logic [47:0] sa, input logic [47:0] da,
                        input logic [2:0] d, input logic f);
        @(posedge ref_clk);
        lkValid <= 1'b1;
        lkSrcPort <= s;
        lkSrcMac <= sa;
        lkDstMac <= da;
        @(posedge ref_clk);
        for (k = 0; k < 2000 && lkReady !== 1'b1; k++)
            @(posedge ref_clk);
        lkValid <= 1'b0;
        bound(k >= 2000);
        @(posedge ref_clk);
        gExt = {resPrioValid, resPrio, resTreeOvr};
        `CHK({resValid, resFilter}, {1'b1, f})
        if (!f)
            `CHK(resDest, d)
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial
    begin
        {rst, lkValid, psel, penable, pwrite, ageTest, ageEnable, daPrioEnable} = 8'h81;
        {lkSrcPort, lkSrcMac, lkDstMac, paddr, pwdata, overrideEnable, overrideDest} = '0;
        learnEnable = 3'h7;
        ageTime = 20'h0_0001;
        portState = '{PS_FORWARDING, PS_FORWARDING, PS_FORWARDING};
        rows[0] = '{2'h0, MA, MU, 3'h6, 1'b0};
        rows[1] = '{2'h1, MB, MA, 3'h1, 1'b0};
        rows[2] = '{2'h2, MC, MB, 3'h2, 1'b0};
        rows[3] = '{2'h1, MA, MB, 3'h2, 1'b1};
        rows[4] = '{2'h2, MC, MA, 3'h2, 1'b0};
        rows[5] = '{2'h1, MA, MM, 3'h6, 1'b0};
        rows[6] = '{2'h1, MA, MF, 3'h0, 1'b1};
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, `REG_STATUS, 32'h0000_0000);
        `CHK(rdat, 32'h0000_0000)
        make(MM, 12'hB1E);
        make(MF, 12'h098);
        make(MS, 12'h059);
        for (int i = 0; i < 7; i++)
        begin
            look(rows[i].src, rows[i].sa, rows[i].da, rows[i].dest, rows[i].filt);
            `CHK({gExt[4], gExt[0]}, {rows[i].da == MM, 1'b0})
            if (rows[i].da == MM)
                `CHK(gExt[3:1], 3'h5)
        end
        portState[1] <= PS_BLOCKING;
        look(2'h1, MS, MC, 3'h4, 1'b1);
        look(2'h1, MS, MS, 3'h1, 1'b0);
        `CHK(gExt[0], 1'b1)
        portState[1] <= PS_DISABLED;
        look(2'h1, MS, MS, 3'h1, 1'b1);
        portState[1] <= PS_FORWARDING;
        look(2'h2, MS, MS, 3'h1, 1'b0);
        daPrioEnable <= 1'b0;
        look(2'h0, MS, MM, 3'h6, 1'b0);
        `CHK(gExt[4], 1'b0)
        overrideEnable <= 3'h4;
        overrideDest <= 9'h040;
        look(2'h2, MS, MB, 3'h1, 1'b0);
        look(2'h2, MS, MF, 3'h1, 1'b1);
        overrideEnable <= 3'h0;
        learnEnable <= 3'h6;
        look(2'h0, MD, MA, 3'h2, 1'b0);
        learnEnable <= 3'h7;
        look(2'h1, MS, MD, 3'h5, 1'b0);
        make(MC, 12'h000);
        look(2'h0, MS, MC, 3'h6, 1'b0);
        apb(1'b1, 12'h100, 32'h0000_0000);
        `CHK(rerr, 1'b1)
        cmd(32'h0000_0002);
        `CHK(st0[`STS_PENDING_BIT], 1'b1)
        apb(1'b0, `REG_READ_LOW, 32'h0000_0000);
        `CHK(rdat, MA[31:0])
        n = 0;
        for (int i = 0; i < 600; i++)
        begin
            apb(1'b0, `REG_READ_HIGH, 32'h0000_0000);
            n += int'(rdat[`HI_VALID_BIT] === 1'b1);
            if (rdat[`HI_END_BIT] !== 1'b0)
                break;
            cmd(32'h0000_0004);
        end
        `CHK(rdat[`HI_END_BIT], 1'b1)
        `CHK(n, 5)
        ageEnable <= 1'b1;
        repeat (5000) @(posedge ref_clk);
        look(2'h2, MS, MA, 3'h2, 1'b0);
        ageEnable <= 1'b0;
        ageTest <= 1'b1;
        repeat (5000) @(posedge ref_clk);
        look(2'h2, MS, MA, 3'h2, 1'b0);
        ageEnable <= 1'b1;
        look(2'h0, ME, MB, 3'h2, 1'b0);
        // two scans at most: entry survives
        repeat (2200) @(posedge ref_clk);
        look(2'h2, MS, ME, 3'h1, 1'b0);
        repeat (2400) @(posedge ref_clk);
        look(2'h2, MS, ME, 3'h3, 1'b0);
        look(2'h2, MS, MS, 3'h1, 1'b0);
        rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        look(2'h1, MS, MS, 3'h5, 1'b0);
        give_verdict();
    end
endmodule // tb_switch_address_table_engine
